// ### verilog/ps2_port_pkg.sv
// Package: constants, states and carriers for the two-wire keyboard port controller
package ps2_port_pkg;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 125_000_000;
   localparam int FSM_HZ = 2_000_000;
   localparam int TICK_DIV = CLK_HZ / FSM_HZ;
   localparam int RTS_NS = 80;
   localparam int RTS_CYCLES = (RTS_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int TIMEOUT_US = 2000;
   localparam int TIMEOUT_TICKS = (TIMEOUT_US * (FSM_HZ / 1_000_000));
   // -----------------------------------------------------------------
   // Frame layout and reset values
   // -----------------------------------------------------------------
   localparam int FRAME_BITS = 11;
   localparam logic [3:0] PARITY_POS = 4'h9;
   localparam logic [3:0] STOP_POS = 4'hA;
   localparam logic [7:0] RX_BYTE_RESET = 8'hFF;
   localparam logic [9:0] TX_SHIFT_RESET = 10'h000;
   localparam logic [3:0] BITCNT_RESET = 4'h0;

   typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX} state_t;

   // One clock/data pair of a port
   typedef struct packed {
      logic clk;
      logic dat;
   } line_pair_t;

   // Status flags presented to software
   typedef struct packed {
      logic rx_ready;
      logic parity_err;
      logic frame_err;
      logic timeout;
      logic xmit_idle;
   } status_t;
endpackage : ps2_port_pkg

// ### verilog/ps2_port_controller.sv
// Module: two-wire keyboard/mouse port controller with receive, transmit and wake
`timescale 1ns/1ps

module ps2_port_controller
   import ps2_port_pkg::*;
#(
   parameter int NPORTS = 2
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic nrst_i,
   // Control
   input wire logic enable_i,
   input wire logic tx_mode_i,
   input wire logic [((NPORTS > 1) ? $clog2(NPORTS) : 1)-1:0] port_sel_i,
   input wire logic tx_start_i,
   input wire logic [7:0] tx_byte_i,
   input wire logic rx_read_i,
   input wire logic err_clear_i,
   input wire logic [NPORTS-1:0] wake_en_i,
   // Status
   output logic [7:0] rx_byte_o,
   output status_t status_o,
   output logic tx_done_o,
   output logic sleep_ok_o,
   output logic port_activity_irq_o,
   output logic [NPORTS-1:0] port_wake_request_o,
   // Pins, open drain
   input wire line_pair_t [NPORTS-1:0] kbd_line_i,
   output line_pair_t [NPORTS-1:0] kbd_line_o,
   output line_pair_t [NPORTS-1:0] kbd_line_oe_o
);
   localparam int PW = (NPORTS > 1) ? $clog2(NPORTS) : 1;

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   logic [NPORTS-1:0] clk_in, dat_in;
   logic [NPORTS-1:0] cs1_q, cs2_q, cs3_q, clk_f_q;
   logic [NPORTS-1:0] ds1_q, ds2_q, ds3_q, dat_f_q;

   always_comb begin
      for (int p = 0; p < NPORTS; p++) begin
         clk_in[p] = kbd_line_i[p].clk;
         dat_in[p] = kbd_line_i[p].dat;
      end
   end

   // A level counts only once the second and third stages agree
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cs1_q <= '1;
         cs2_q <= '1;
         cs3_q <= '1;
         clk_f_q <= '1;
         ds1_q <= '1;
         ds2_q <= '1;
         ds3_q <= '1;
         dat_f_q <= '1;
      end else begin
         cs1_q <= clk_in;
         cs2_q <= cs1_q;
         cs3_q <= cs2_q;
         clk_f_q <= (cs2_q & cs3_q) | (clk_f_q & (cs2_q ^ cs3_q));
         ds1_q <= dat_in;
         ds2_q <= ds1_q;
         ds3_q <= ds2_q;
         dat_f_q <= (ds2_q & ds3_q) | (dat_f_q & (ds2_q ^ ds3_q));
      end
   end

   // -----------------------------------------------------------------
   // Port selection and edge detect
   // -----------------------------------------------------------------
   state_t state_q;
   logic [PW-1:0] port_q;
   logic clk_prev_q;
   logic clk_sel, dat_sel, fall;

   assign clk_sel = clk_f_q[port_q];
   assign dat_sel = dat_f_q[port_q];
   assign fall = clk_prev_q & ~clk_sel;

   // Port may only change between frames, so one port is live at a time
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         port_q <= '0;
         clk_prev_q <= 1'b1;
      end else begin
         if (state_q == ST_IDLE && port_sel_i < NPORTS) begin
            port_q <= port_sel_i;
         end
         clk_prev_q <= clk_sel;
      end
   end

   // -----------------------------------------------------------------
   // 2 MHz pacing and no-edge timeout
   // -----------------------------------------------------------------
   logic [6:0] div_q;
   logic tick;
   logic [12:0] idle_cnt_q;
   logic timed_out;

   assign tick = (div_q == 7'(TICK_DIV - 1));
   // Timeout far exceeds the longest cell, so slow devices still pass
   assign timed_out = (idle_cnt_q == 13'(TIMEOUT_TICKS));

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_q <= '0;
         idle_cnt_q <= '0;
      end else begin
         div_q <= tick ? 7'h00 : div_q + 7'h01;
         if (state_q == ST_IDLE || fall || timed_out) begin
            idle_cnt_q <= '0;
         end else if (tick) begin
            idle_cnt_q <= idle_cnt_q + 13'h0001;
         end
      end
   end

   // -----------------------------------------------------------------
   // Frame state machine
   // -----------------------------------------------------------------
   logic [3:0] bitcnt_q;
   logic [8:0] rx_sr_q;
   logic start_q;
   logic [9:0] tx_sr_q;
   logic dat_oe_q;
   logic rx_ready_q, parity_err_q, frame_err_q, timeout_q, tx_done_q;
   logic [7:0] rx_byte_q;
   logic tx_go, rx_end, rx_good, rx_abort;

   assign tx_go = tx_start_i & enable_i & tx_mode_i & (state_q == ST_IDLE) & ~rx_ready_q;
   assign rx_end = (state_q == ST_RX) & fall & (bitcnt_q == STOP_POS);
   assign rx_good = rx_end & ~start_q & dat_sel & (^rx_sr_q);
   // Dropping enable or turning to transmit before parity discards the byte
   assign rx_abort = (state_q == ST_RX) & (~enable_i | tx_mode_i) & (bitcnt_q < PARITY_POS);

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= ST_IDLE;
         bitcnt_q <= BITCNT_RESET;
         rx_sr_q <= '0;
         start_q <= 1'b1;
         tx_sr_q <= TX_SHIFT_RESET;
         dat_oe_q <= 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               bitcnt_q <= BITCNT_RESET;
               if (tx_go) begin
                  // Stop, odd parity, then payload shifted out LSB first
                  tx_sr_q <= {1'b1, ~^tx_byte_i, tx_byte_i};
                  dat_oe_q <= 1'b1;
                  state_q <= ST_TX;
               end else if (enable_i && !tx_mode_i && !rx_ready_q && fall) begin
                  start_q <= dat_sel;
                  bitcnt_q <= 4'h1;
                  state_q <= ST_RX;
               end
            end
            ST_RX: begin
               if (rx_abort || timed_out) begin
                  state_q <= ST_IDLE;
               end else if (fall) begin
                  bitcnt_q <= bitcnt_q + 4'h1;
                  if (bitcnt_q == STOP_POS) begin
                     state_q <= ST_IDLE;
                  end else begin
                     rx_sr_q <= {dat_sel, rx_sr_q[8:1]};
                  end
               end
            end
            ST_TX: begin
               if (timed_out || !enable_i) begin
                  dat_oe_q <= 1'b0;
                  state_q <= ST_IDLE;
               end else if (fall) begin
                  bitcnt_q <= bitcnt_q + 4'h1;
                  // Pull low for a zero, release for a one
                  dat_oe_q <= (bitcnt_q < STOP_POS) ? ~tx_sr_q[0] : 1'b0;
                  tx_sr_q <= {1'b0, tx_sr_q[9:1]};
                  if (bitcnt_q == STOP_POS) begin
                     state_q <= ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Receive buffer and status flags; a set beats a same-cycle clear
   // -----------------------------------------------------------------
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_ready_q <= 1'b0;
         rx_byte_q <= RX_BYTE_RESET;
         parity_err_q <= 1'b0;
         frame_err_q <= 1'b0;
         timeout_q <= 1'b0;
         tx_done_q <= 1'b0;
      end else begin
         tx_done_q <= (state_q == ST_TX) & fall & (bitcnt_q == STOP_POS);
         if (rx_good) begin
            rx_ready_q <= 1'b1;
            rx_byte_q <= rx_sr_q[7:0];
         end else if (rx_read_i || timed_out) begin
            rx_ready_q <= rx_read_i ? 1'b0 : rx_ready_q;
            rx_byte_q <= RX_BYTE_RESET;
         end
         if (rx_end && !(^rx_sr_q)) begin
            parity_err_q <= 1'b1;
         end else if (err_clear_i) begin
            parity_err_q <= 1'b0;
         end
         if (rx_end && (start_q || !dat_sel)) begin
            frame_err_q <= 1'b1;
         end else if (err_clear_i) begin
            frame_err_q <= 1'b0;
         end
         if (timed_out && state_q != ST_IDLE) begin
            timeout_q <= 1'b1;
         end else if (err_clear_i) begin
            timeout_q <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   logic clk_oe;
   // Clock is only ever held low, never toggled: the peripheral clocks bits
   assign clk_oe = enable_i & (rx_ready_q | (tx_mode_i & (state_q == ST_IDLE)));

   always_comb begin
      for (int p = 0; p < NPORTS; p++) begin
         kbd_line_o[p] = '{clk: 1'b0, dat: 1'b0};
         kbd_line_oe_o[p].clk = clk_oe & (port_q == PW'(p));
         kbd_line_oe_o[p].dat = dat_oe_q & (port_q == PW'(p));
         // Raw pin, no clock: a low data line after its fall wakes the core
         port_wake_request_o[p] = wake_en_i[p] & ~kbd_line_i[p].dat;
      end
   end

   assign rx_byte_o = rx_byte_q;
   assign status_o = '{rx_ready: rx_ready_q, parity_err: parity_err_q,
                       frame_err: frame_err_q, timeout: timeout_q,
                       xmit_idle: (state_q != ST_TX)};
   assign tx_done_o = tx_done_q;
   assign port_activity_irq_o = rx_ready_q | parity_err_q | frame_err_q
                                | timeout_q | tx_done_q;
   assign sleep_ok_o = ~enable_i | (~tx_mode_i & (state_q == ST_IDLE) & ~rx_ready_q
                                    & clk_sel & dat_sel);

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   a_rts_start: assert property (tx_go |=> state_q == ST_TX && dat_oe_q && !clk_oe)
      else $error("transmit start did not request to send");
   a_ready_hold: assert property (rx_ready_q && enable_i |-> clk_oe)
      else $error("clock not held low while byte waits");
   a_inhibit_drive: assert property (enable_i && tx_mode_i && state_q == ST_IDLE |-> clk_oe && !dat_oe_q)
      else $error("inhibit state wrong");
   a_good_byte: assert property (rx_good |=> rx_ready_q && rx_byte_q == $past(rx_sr_q[7:0]))
      else $error("good frame not presented");
   a_parity_bad: assert property (rx_end && !(^rx_sr_q) |=> parity_err_q && !rx_ready_q)
      else $error("parity fault not reported");
   a_frame_bad: assert property (rx_end && start_q |=> frame_err_q)
      else $error("start bit fault not reported");
   a_frame_len: assert property (rx_end |=> state_q == ST_IDLE && bitcnt_q == STOP_POS + 4'h1)
      else $error("frame did not end after eleven cells");
   a_port_hold: assert property (state_q != ST_IDLE ##1 state_q != ST_IDLE |-> $stable(port_q))
      else $error("port changed during a frame");
   a_sleep_gate: assert property (sleep_ok_o && enable_i |-> !tx_mode_i && state_q == ST_IDLE)
      else $error("sleep allowed while busy");
   a_read_clear: assert property (rx_read_i && !rx_good |=> !rx_ready_q && rx_byte_o == RX_BYTE_RESET)
      else $error("read did not release buffer");
   a_tx_bit: assert property ((state_q == ST_TX) && fall && bitcnt_q == 4'h0 && enable_i && !timed_out
                              |=> dat_oe_q == ~$past(tx_sr_q[0]))
      else $error("first payload bit wrong");
   a_sample_fall: assert property ((state_q == ST_RX) && !fall |=> $stable(bitcnt_q) || state_q == ST_IDLE)
      else $error("bit taken without falling clock");
endmodule : ps2_port_controller

// ### verification/ps2_dev_model.sv
// Behavioural keyboard-side model for one port
`timescale 1ns/1ps
module ps2_dev_model #(
   parameter real HALF_NS = 62.5
) (
   // Wire levels
   input wire logic clk_line_i,
   input wire logic dat_line_i,
   // Pulls, high = pull low
   output logic clk_pull_o,
   output logic dat_pull_o
);
   // ----------------------------------------
   // Frames in both directions
   // ----------------------------------------
   initial begin
      clk_pull_o = 1'b0;
      dat_pull_o = 1'b0;
   end
   task automatic send_frame(input logic [7:0] b, input logic par_flip, input logic stop_v);
      logic [10:0] f;
      f = {stop_v, (~^b) ^ par_flip, b, 1'b0};
      wait (clk_line_i === 1'b1);
      // Idle wait is scaled down with the cell length
      #(4 * HALF_NS);
      for (int i = 0; i < 11; i++) begin
         dat_pull_o = ~f[i];
         #(HALF_NS);
         clk_pull_o = 1'b1;
         #(HALF_NS);
         clk_pull_o = 1'b0;
      end
      dat_pull_o = 1'b0;
   endtask : send_frame
   task automatic recv_frame(output logic [9:0] f);
      wait (dat_line_i === 1'b0 && clk_line_i === 1'b1);
      #(HALF_NS);
      for (int i = 0; i < 10; i++) begin
         clk_pull_o = 1'b1;
         #(HALF_NS);
         clk_pull_o = 1'b0;
         f[i] = dat_line_i;
         #(HALF_NS);
      end
      clk_pull_o = 1'b1;
      fork
         #(HALF_NS) clk_pull_o = 1'b0;
      join_none
   endtask : recv_frame
endmodule : ps2_dev_model

// ### verification/ps2_port_controller_tb.sv
// Self-checking bench for the two-wire port controller
`timescale 1ns/1ps
module ps2_port_controller_tb;
   import ps2_port_pkg::*;
   // ----------------------------------------
   // Stimulus and wires
   // ----------------------------------------
   logic clock_i = 1'b0;
   logic nrst_i = 1'b0;
   logic enable_i = 1'b0;
   logic tx_mode_i = 1'b0;
   logic [0:0] port_sel_i = 1'h0;
   logic tx_start_i = 1'b0;
   logic [7:0] tx_byte_i = 8'h00;
   logic rx_read_i = 1'b0;
   logic err_clear_i = 1'b0;
   logic [1:0] wake_en_i = 2'h0;
   logic p1_dat_pull = 1'b0;
   logic [7:0] rx_byte_o;
   status_t status_o;
   logic tx_done_o;
   logic sleep_ok_o;
   logic port_activity_irq_o;
   logic [1:0] port_wake_request_o;
   line_pair_t [1:0] pins;
   line_pair_t [1:0] oe_o;
   line_pair_t [1:0] line_o;
   logic dev_clk;
   logic dev_dat;
   int failures = 0;
   int checked = 0;
   int cycles = 0;
   assign pins[0].clk = ~(oe_o[0].clk | dev_clk);
   assign pins[0].dat = ~(oe_o[0].dat | dev_dat);
   assign pins[1].clk = ~oe_o[1].clk;
   assign pins[1].dat = ~(oe_o[1].dat | p1_dat_pull);
   always #4 clock_i = ~clock_i;
   ps2_port_controller #(.NPORTS(2)) ps2_port_controller_inst (
      .clock_i(clock_i), .nrst_i(nrst_i), .enable_i(enable_i), .tx_mode_i(tx_mode_i),
      .port_sel_i(port_sel_i), .tx_start_i(tx_start_i), .tx_byte_i(tx_byte_i),
      .rx_read_i(rx_read_i), .err_clear_i(err_clear_i), .wake_en_i(wake_en_i),
      .rx_byte_o(rx_byte_o), .status_o(status_o), .tx_done_o(tx_done_o),
      .sleep_ok_o(sleep_ok_o), .port_activity_irq_o(port_activity_irq_o),
      .port_wake_request_o(port_wake_request_o), .kbd_line_i(pins), .kbd_line_o(line_o),
      .kbd_line_oe_o(oe_o));
   ps2_dev_model ps2_dev_model_inst (.clk_line_i(pins[0].clk), .dat_line_i(pins[0].dat),
      .clk_pull_o(dev_clk), .dat_pull_o(dev_dat));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   task automatic wait_irq;
      int n;
      n = 0;
      while (port_activity_irq_o !== 1'b1 && n < 60) begin
         @(posedge clock_i);
         #1 n++;
      end
   endtask : wait_irq
   task automatic check_defaults;
      check("byte", 16'(rx_byte_o), 16'h00FF);
      check("status", 16'(status_o), 16'h0001);
      check("outs", 16'({oe_o, tx_done_o, port_activity_irq_o}), 16'h0000);
      check("drive level", 16'(line_o), 16'h0000);
   endtask : check_defaults
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic rx_case(input logic [7:0] b, input logic par_flip, input logic stop_v);
      logic good;
      good = !par_flip && stop_v;
      ps2_dev_model_inst.send_frame(b, par_flip, stop_v);
      wait_irq();
      check("rx status", 16'(status_o), good ? 16'h0011 : (par_flip ? 16'h0009 : 16'h0005));
      check("irq", 16'(port_activity_irq_o), 16'h0001);
      check("clk hold", 16'(oe_o[0].clk), 16'(good));
      if (good) begin
         check("rx byte", 16'(rx_byte_o), 16'(b));
         @(posedge clock_i) rx_read_i <= 1'b1;
         @(posedge clock_i) rx_read_i <= 1'b0;
         @(posedge clock_i);
         #1 check("read", 16'({rx_byte_o, status_o.rx_ready, oe_o[0].clk}), 16'h03FC);
      end else begin
         @(posedge clock_i) err_clear_i <= 1'b1;
         @(posedge clock_i) err_clear_i <= 1'b0;
         @(posedge clock_i);
         #1 check("cleared", 16'(status_o), 16'h0001);
      end
      $display("rx test done %h", b);
   endtask : rx_case
   task automatic tx_case(input logic [7:0] b);
      logic [9:0] got;
      int n;
      @(posedge clock_i) tx_mode_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      #1 check("inhibit", 16'({oe_o[0].clk, oe_o[0].dat}), 16'h0002);
      @(posedge clock_i) tx_byte_i <= b;
      tx_start_i <= 1'b1;
      @(posedge clock_i) tx_start_i <= 1'b0;
      #1 check("rts", 16'({oe_o[0].clk, oe_o[0].dat}), 16'h0001);
      check("sleep tx", 16'({sleep_ok_o, status_o.xmit_idle}), 16'h0000);
      ps2_dev_model_inst.recv_frame(got);
      n = 0;
      while (tx_done_o !== 1'b1 && n < 30) begin
         @(posedge clock_i);
         #1 n++;
      end
      check("tx done", 16'(tx_done_o), 16'h0001);
      check("frame", 16'(got), 16'({1'b1, ~^b, b}));
      @(posedge clock_i) tx_mode_i <= 1'b0;
      $display("tx test done %h", b);
   endtask : tx_case
   task automatic sel_case;
      @(posedge clock_i) port_sel_i <= 1'h1;
      @(posedge clock_i);
      ps2_dev_model_inst.send_frame(8'h3C, 1'b0, 1'b1);
      wait_irq();
      check("other port", 16'({port_activity_irq_o, oe_o}), 16'h0000);
      @(posedge clock_i) port_sel_i <= 1'h0;
      $display("port select test done");
   endtask : sel_case
   task automatic wake_case;
      @(posedge clock_i) wake_en_i <= 2'h2;
      p1_dat_pull <= 1'b1;
      #1 check("wake", 16'(port_wake_request_o), 16'h0002);
      @(posedge clock_i) p1_dat_pull <= 1'b0;
      #1 check("wake off", 16'(port_wake_request_o), 16'h0000);
      $display("wake test done");
   endtask : wake_case
   task automatic reset_case;
      ps2_dev_model_inst.send_frame(8'h96, 1'b0, 1'b1);
      wait_irq();
      @(posedge clock_i) tx_mode_i <= 1'b1;
      tx_start_i <= 1'b1;
      @(posedge clock_i) tx_start_i <= 1'b0;
      @(posedge clock_i);
      #1 check("refused", 16'({oe_o[0].dat, status_o.xmit_idle}), 16'h0001);
      @(posedge clock_i) nrst_i <= 1'b0;
      tx_mode_i <= 1'b0;
      #1 check_defaults();
      @(posedge clock_i) nrst_i <= 1'b1;
      $display("reset test done");
   endtask : reset_case
   // Hang guard, far above the expected run length
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         end_of_test();
      end
   end
   initial begin
      repeat (8) @(posedge clock_i);
      #1 check("sleep off", 16'(sleep_ok_o), 16'h0001);
      check_defaults();
      @(posedge clock_i) nrst_i <= 1'b1;
      enable_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      #1 check("sleep idle", 16'(sleep_ok_o), 16'h0001);
      rx_case(8'hA5, 1'b0, 1'b1);
      rx_case(8'h00, 1'b0, 1'b1);
      rx_case(8'h80, 1'b0, 1'b1);
      rx_case(8'h5B, 1'b1, 1'b1);
      rx_case(8'h5B, 1'b0, 1'b0);
      tx_case(8'h5A);
      tx_case(8'hFF);
      sel_case();
      wake_case();
      reset_case();
      end_of_test();
   end
endmodule : ps2_port_controller_tb
